// *** dlfc_consts.svh ***
// Constants for the loop filter and synthesizer core
`ifndef DLFC_CONSTS_SVH
`define DLFC_CONSTS_SVH
`define DLFC_TW_W       48
`define DLFC_PHS_W      16
`define DLFC_ERR_W      24
`define DLFC_DFS_W      10
`define DLFC_AMP_W      14
`define DLFC_PEXP_W     5
`define DLFC_PEXP_MIN   5'd5
`define DLFC_PEXP_MAX   5'd16
`define DLFC_DIVCNT_W   16
`define DLFC_DFS_BASE   16'd72
`define DLFC_DFS_SPAN   16'd192
`define DLFC_DFS_SHIFT  10
`define DLFC_SHIFT_W    5
`define DLFC_AMP_FULL   14'h1fff
`endif

// *** dlfc_core.sv ***
// Digital loop filter, comb-integrator interpolator and phase accumulator synthesizer
`include "dlfc_consts.svh"
module dlfc_core
  import dlfc_pkg::*;
(
  input  wire logic                     i_core_clk,          // DAC sample clock
  input  wire logic                     i_rst_b,             // Sync reset, active low
  input  wire dlfc_cfg_t                i_cfg,               // Loop configuration
  input  wire logic [`DLFC_TW_W-1:0]    i_single_tone_tuning_word, // Open-loop word
  input  wire logic [`DLFC_PHS_W-1:0]   i_phase_offset,      // Programmed phase offset
  input  wire dlfc_word_t               i_estimate,          // Estimator result
  input  wire logic                     i_err_valid,         // Phase error strobe
  input  wire logic signed [`DLFC_ERR_W-1:0] i_err,          // Phase error sample
  input  wire logic                     i_ref_lost,          // Reference lost, pin
  input  wire logic [`DLFC_DFS_W-1:0]   i_dac_full_scale_code, // Full-scale code
  output logic [`DLFC_AMP_W-1:0]        o_dac_sample,        // Sine sample, offset binary
  output logic [`DLFC_TW_W-1:0]         o_tuning_word,       // Applied tuning word
  output logic [`DLFC_PEXP_W-1:0]       o_p_exp,             // Exponent in use
  output logic [15:0]                   o_fs_factor,         // Full-scale factor, Q10
  output logic [3:0]                    o_mode,              // Current mode, one-hot
  output logic                          o_holdover_valid     // Loop has been closed
);
  localparam int unsigned AW = `DLFC_TW_W;
  // Reference-lost pin synchroniser
  logic ref_s1_q, ref_s1_d, ref_s2_q, ref_s2_d;
  // Rate divider and filter state
  logic [`DLFC_PEXP_W-1:0]   pexp_q, pexp_d;
  logic [`DLFC_DIVCNT_W-1:0] div_q, div_d;
  logic                      tick;
  logic signed [`DLFC_ERR_W-1:0] err_q, err_d;
  logic signed [AW-1:0] integ_q, integ_d, filt_q, filt_d;
  // Interpolator: two combs at fs/P, two integrators at fs
  logic signed [AW-1:0] c1_q, c1_d, c2_q, c2_d, cd1_q, cd1_d, cd2_q, cd2_d;
  logic signed [AW+32-1:0] i1_q, i1_d, i2_q, i2_d;
  // Mode and synthesizer
  dlfc_mode_t mode_q, mode_d;
  logic              hv_q, hv_d;
  logic [AW-1:0]     hold_q, hold_d, tw_q, tw_d, acc_q, acc_d;
  logic [`DLFC_PHS_W-1:0] ph_q, ph_d, phsum;
  logic [`DLFC_AMP_W-1:0] amp_q, amp_d;
  logic [15:0]       fsf_q, fsf_d;
  logic signed [AW-1:0] err_ext;

  // Parabolic sine approximation from phase; lookup ROM would be used in silicon
  function automatic logic [`DLFC_AMP_W-1:0] sine_of(input logic [`DLFC_PHS_W-1:0] p);
    logic [14:0] x;
    logic [29:0] sq;
    logic [14:0] mag;
    x   = p[14:0];
    sq  = 30'(x) * 30'(15'h7fff - x);
    mag = 15'(sq >> 16);
    sine_of = p[15] ? 14'(`DLFC_AMP_FULL - 14'(mag >> 2))
                    : 14'(`DLFC_AMP_FULL + 14'(mag >> 2));
  endfunction

  always_comb begin
    ref_s1_d = i_ref_lost;
    ref_s2_d = ref_s1_q;
    // Clamp out-of-range exponents rather than run an unsupported ratio
    if (i_cfg.p_exp < `DLFC_PEXP_MIN) begin
      pexp_d = `DLFC_PEXP_MIN;
    end else if (i_cfg.p_exp > `DLFC_PEXP_MAX) begin
      pexp_d = `DLFC_PEXP_MAX;
    end else begin
      pexp_d = i_cfg.p_exp;
    end
    // Compare is >= so a lowered exponent never waits for a full counter wrap
    tick  = (div_q >= 16'((17'd1 << pexp_q) - 17'd1));
    div_d = tick ? '0 : 16'(div_q + 16'd1);
    // Latest compare-rate sample held until the next strobe while closed
    err_d = (i_err_valid && mode_q == DLFC_CLOSED) ? i_err : err_q;
    err_ext = AW'(err_q);
    integ_d = integ_q;
    filt_d  = filt_q;
    if (tick) begin
      integ_d = integ_q + (err_ext <<< i_cfg.k_int);
      filt_d  = integ_q + (err_ext <<< i_cfg.k_prop);
    end
    // Combs update at fs/P; zero-stuffed integrators each clock give gain P
    c1_d = c1_q; cd1_d = cd1_q; c2_d = c2_q; cd2_d = cd2_q;
    if (tick) begin
      cd1_d = filt_q;
      c1_d  = filt_q - cd1_q;
      cd2_d = c1_d;
      c2_d  = c1_d - cd2_q;
    end
    i1_d = i1_q + (tick ? (AW+32)'(c2_q) : '0);
    i2_d = i2_q + i1_q;
    // Mode selection
    hv_d = hv_q | (mode_q == DLFC_CLOSED);
    // Saved word is the one applied while closed, so holdover has no step
    hold_d = (mode_q == DLFC_CLOSED) ? tw_q : hold_q;
    mode_d = mode_q;
    case (mode_q)
      DLFC_CLOSED: begin
        if (!i_cfg.loop_close) begin
          mode_d = i_cfg.use_estimate ? DLFC_ESTIMATE : DLFC_SINGLE;
        end else if (i_cfg.man_holdover || (i_cfg.auto_holdover && ref_s2_q)) begin
          mode_d = DLFC_HOLDOVER;
        end
      end
      DLFC_HOLDOVER: begin
        if (!i_cfg.loop_close) begin
          mode_d = i_cfg.use_estimate ? DLFC_ESTIMATE : DLFC_SINGLE;
        end else if (!i_cfg.man_holdover && !(i_cfg.auto_holdover && ref_s2_q)) begin
          mode_d = DLFC_CLOSED;
        end
      end
      DLFC_SINGLE, DLFC_ESTIMATE: begin
        if (i_cfg.loop_close) begin
          mode_d = DLFC_CLOSED;
        end else begin
          mode_d = i_cfg.use_estimate ? DLFC_ESTIMATE : DLFC_SINGLE;
        end
      end
      default: mode_d = DLFC_SINGLE;
    endcase
    // Holdover without a saved word stays on the single-tone word
    case (mode_q)
      // One shift by the exponent removes the interpolator gain P: unity at DC
      DLFC_CLOSED:   tw_d = AW'(i2_q >>> pexp_q);
      DLFC_HOLDOVER: tw_d = hv_q ? hold_q : i_single_tone_tuning_word;
      DLFC_ESTIMATE: tw_d = i_estimate.tuning_word;
      default:       tw_d = i_single_tone_tuning_word;
    endcase
    case (mode_q)
      DLFC_CLOSED:   ph_d = '0;
      DLFC_ESTIMATE: ph_d = i_estimate.phase;
      default:       ph_d = i_phase_offset;
    endcase
    acc_d = acc_q + tw_q;
    phsum = acc_q[AW-1 -: `DLFC_PHS_W] + ph_q;
    amp_d = sine_of(phsum);
    fsf_d = 16'(`DLFC_DFS_BASE + 16'((26'(`DLFC_DFS_SPAN) * 26'(i_dac_full_scale_code))
            >> `DLFC_DFS_SHIFT));
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      ref_s1_q <= 1'b0; ref_s2_q <= 1'b0;
      pexp_q <= `DLFC_PEXP_MIN; div_q <= '0; err_q <= '0;
      integ_q <= '0; filt_q <= '0;
      c1_q <= '0; c2_q <= '0; cd1_q <= '0; cd2_q <= '0; i1_q <= '0; i2_q <= '0;
      mode_q <= DLFC_SINGLE; hv_q <= 1'b0; hold_q <= '0; tw_q <= '0;
      acc_q <= '0; ph_q <= '0; amp_q <= '0; fsf_q <= `DLFC_DFS_BASE;
    end else begin
      ref_s1_q <= ref_s1_d; ref_s2_q <= ref_s2_d;
      pexp_q <= pexp_d; div_q <= div_d; err_q <= err_d;
      integ_q <= integ_d; filt_q <= filt_d;
      c1_q <= c1_d; c2_q <= c2_d; cd1_q <= cd1_d; cd2_q <= cd2_d; i1_q <= i1_d; i2_q <= i2_d;
      mode_q <= mode_d; hv_q <= hv_d; hold_q <= hold_d; tw_q <= tw_d;
      acc_q <= acc_d; ph_q <= ph_d; amp_q <= amp_d; fsf_q <= fsf_d;
    end
  end

  assign o_dac_sample     = amp_q;
  assign o_tuning_word    = tw_q;
  assign o_p_exp          = pexp_q;
  assign o_fs_factor      = fsf_q;
  assign o_mode           = mode_q;
  assign o_holdover_valid = hv_q;

  // Accumulator, divider, filter, comb, error-input and full-scale checks
  acc_wrap_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ##1 acc_q == AW'($past(acc_q) + $past(tw_q))) else $error("accumulator step wrong");
  pexp_range_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ##1 (pexp_q >= `DLFC_PEXP_MIN && pexp_q <= `DLFC_PEXP_MAX)) else $error("exponent range");
  tick_period_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    tick |=> div_q == '0 ##1 div_q == 16'd1) else $error("divider period");
  filter_rate_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !tick |=> integ_q == $past(integ_q)) else $error("filter moved between ticks");
  comb_rate_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !tick |=> c2_q == $past(c2_q)) else $error("comb moved between ticks");
  err_ignore_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    mode_q != DLFC_CLOSED |=> err_q == $past(err_q)) else $error("error taken while open");
  fs_factor_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ##1 (fsf_q >= `DLFC_DFS_BASE && fsf_q < `DLFC_DFS_BASE + `DLFC_DFS_SPAN))
    else $error("full-scale factor out of range");
  // Mode, word and phase selection checks
  closed_word_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    mode_q == DLFC_CLOSED |=> tw_q == AW'($past(i2_q) >>> $past(pexp_q)))
    else $error("closed word not filter");
  closed_phase_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    mode_q == DLFC_CLOSED |=> ph_q == '0) else $error("offset used while closed");
  single_word_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    mode_q == DLFC_SINGLE |=> tw_q == $past(i_single_tone_tuning_word))
    else $error("single tone word wrong");
  offset_phase_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    mode_q inside {DLFC_SINGLE, DLFC_HOLDOVER} |=> ph_q == $past(i_phase_offset))
    else $error("programmed offset not applied");
  est_word_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    mode_q == DLFC_ESTIMATE |=> tw_q == $past(i_estimate.tuning_word))
    else $error("estimator word not applied");
  est_phase_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    mode_q == DLFC_ESTIMATE |=> ph_q == $past(i_estimate.phase))
    else $error("estimator phase not applied");
  close_valid_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    mode_q == DLFC_CLOSED |=> hv_q) else $error("closure not recorded");
  hold_save_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    mode_q == DLFC_CLOSED |=> hold_q == $past(tw_q)) else $error("closed word not saved");
  hold_after_close_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    mode_q == DLFC_HOLDOVER |-> hv_q) else $error("holdover before closure");
  hold_valid_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    mode_q == DLFC_HOLDOVER && hv_q |=> tw_q == $past(hold_q)) else $error("holdover word");
  close_bit_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !i_cfg.loop_close |=> mode_q inside {DLFC_SINGLE, DLFC_ESTIMATE}) else $error("open mode");
  cov_closed_c: cover property (@(posedge i_core_clk) mode_q == DLFC_CLOSED);
  cov_hold_c: cover property (@(posedge i_core_clk) mode_q == DLFC_HOLDOVER && hv_q);
  cov_hold_exit_c: cover property (@(posedge i_core_clk)
    mode_q == DLFC_HOLDOVER ##1 mode_q == DLFC_CLOSED);
  cov_est_c: cover property (@(posedge i_core_clk) mode_q == DLFC_ESTIMATE);
  cov_wrap_c: cover property (@(posedge i_core_clk) acc_d < acc_q);
endmodule

// *** dlfc_err_src.sv ***
// Phase detector stand-in: error strobes at the compare rate
`include "dlfc_consts.svh"
module dlfc_err_src
  import dlfc_pkg::*;
#(
  // Clocks per compare period; with P of 32 this keeps fs/P above 1.5x compare rate
  parameter int RATIO = 64
) (
  input  wire logic                          i_core_clk, // Sample clock
  input  wire logic                          i_en,       // Send samples
  input  wire logic signed [`DLFC_ERR_W-1:0] i_level,    // Error to send
  output logic                               o_valid,    // Sample strobe
  output logic signed [`DLFC_ERR_W-1:0]      o_err       // Error sample
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial begin
    o_valid = 1'b0;
    o_err = '0;
  end
  // Data toggles off the strobe so a stale sample is never mistaken for a fresh one
  always @(negedge i_core_clk) begin
    cnt = (cnt + 1) % RATIO;
    o_valid = i_en && (cnt == 0);
    o_err = o_valid ? i_level : ~o_err;
  end
endmodule

// *** dlfc_pkg.sv ***
// Types shared by the loop filter and synthesizer core
package dlfc_pkg;
  `include "dlfc_consts.svh"
  typedef enum logic [3:0] {
    DLFC_SINGLE   = 4'b0001,
    DLFC_ESTIMATE = 4'b0010,
    DLFC_HOLDOVER = 4'b0100,
    DLFC_CLOSED   = 4'b1000
  } dlfc_mode_t;
  typedef struct packed {
    logic                    loop_close;    // 1 closes the loop
    logic                    use_estimate;  // Open loop from estimator
    logic                    auto_holdover; // Automatic holdover
    logic                    man_holdover;  // Manual holdover request
    logic [`DLFC_PEXP_W-1:0] p_exp;         // P = 2**p_exp
    logic [`DLFC_SHIFT_W-1:0] k_int;        // Integral gain shift
    logic [`DLFC_SHIFT_W-1:0] k_prop;       // Proportional gain shift
  } dlfc_cfg_t;
  typedef struct packed {
    logic [`DLFC_TW_W-1:0]  tuning_word;
    logic [`DLFC_PHS_W-1:0] phase;
  } dlfc_word_t;
endpackage

// *** testbench.sv ***
// Self-checking bench for the loop filter and synthesizer core
module testbench
  import dlfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_b = 1'b0, err_en = 1'b0, ref_lost = 1'b0, ev;
  dlfc_cfg_t cfg;
  dlfc_word_t est;
  logic [47:0] stw, tw, hw;
  logic [15:0] poff, fsf;
  logic [9:0] dac_full_scale_code;
  logic [13:0] smp, s[4];
  logic [4:0] pexp;
  logic [3:0] mode;
  logic hvalid;
  logic signed [23:0] err;
  int failures = 0, cmp_count = 0;
  logic [4:0] p_in[6] = '{5'h00, 5'h04, 5'h05, 5'h10, 5'h11, 5'h1f};
  logic [4:0] p_out[6] = '{5'h05, 5'h05, 5'h05, 5'h10, 5'h10, 5'h10};
  logic [9:0] f_in[4] = '{10'h000, 10'h001, 10'h200, 10'h3ff};
  logic [15:0] f_out[4] = '{16'h0048, 16'h0048, 16'h00a8, 16'h0107};
  always #25 clk = ~clk;
  dlfc_err_src i_dlfc_err_src (.i_core_clk(clk), .i_en(err_en), .i_level(24'sh000100),
    .o_valid(ev), .o_err(err));
  dlfc_core i_dlfc_core (.i_core_clk(clk), .i_rst_b(rst_b), .i_cfg(cfg),
    .i_single_tone_tuning_word(stw), .i_phase_offset(poff), .i_estimate(est),
    .i_err_valid(ev), .i_err(err), .i_ref_lost(ref_lost), .i_dac_full_scale_code(dac_full_scale_code),
    .o_dac_sample(smp), .o_tuning_word(tw), .o_p_exp(pexp), .o_fs_factor(fsf),
    .o_mode(mode), .o_holdover_valid(hvalid));
  task automatic conclude();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string name, logic [47:0] exp, logic [47:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait; a mode that never arrives ends the run
  task automatic wait_mode(logic [3:0] m);
    for (int i = 0; i < 20 && mode !== m; i++) @(negedge clk);
    chk("mode", m, mode);
    if (mode !== m) conclude();
  endtask
  initial begin
    #1000000;
    failures++;
    conclude();
  end
  initial begin
    cfg = '0;
    cfg.p_exp = 5'h05;
    stw = 48'h0;
    poff = 16'h0;
    est = '0;
    dac_full_scale_code = 10'h000;
    tick(12);
    chk("sample", 48'h0, smp);
    chk("word", 48'h0, tw);
    chk("fs_factor", 48'h48, fsf);
    chk("reset mode", 48'h1, mode);
    chk("valid", 48'h0, hvalid);
    rst_b = 1'b1;
    foreach (p_in[i]) begin
      cfg.p_exp = p_in[i];
      tick(3);
      chk("p_exp", p_out[i], pexp);
    end
    // Largest P that still oversamples the compare rate enough
    cfg.p_exp = 5'h05;
    foreach (f_in[i]) begin
      dac_full_scale_code = f_in[i];
      tick(3);
      chk("fs_factor", f_out[i], fsf);
    end
    stw = 48'h04fa05143bf7;
    err_en = 1'b1;
    tick(90);
    chk("single word", stw, tw);
    est.tuning_word = 48'h123456789abc;
    est.phase = 16'h2000;
    cfg.use_estimate = 1'b1;
    wait_mode(4'h2);
    tick(3);
    chk("estimate word", est.tuning_word, tw);
    cfg.use_estimate = 1'b0;
    stw = 48'h400000000000;
    tick(6);
    for (int i = 0; i < 4; i++) begin
      s[i] = smp;
      tick(1);
    end
    chk("sample period", s[0], smp);
    poff = 16'h8000;
    tick(4);
    chk("half turn", s[2], smp);
    tick(1);
    chk("half turn", s[3], smp);
    cfg.loop_close = 1'b1;
    wait_mode(4'h8);
    tick(2);
    chk("valid", 48'h1, hvalid);
    tick(400);
    chk("loop word", 48'h1, tw !== stw && tw !== 48'h0);
    // Word applied while closed, taken before the holdover request
    hw = tw;
    cfg.man_holdover = 1'b1;
    wait_mode(4'h4);
    tick(100);
    chk("held word", hw, tw);
    cfg.man_holdover = 1'b0;
    wait_mode(4'h8);
    cfg.auto_holdover = 1'b1;
    ref_lost = 1'b1;
    wait_mode(4'h4);
    ref_lost = 1'b0;
    wait_mode(4'h8);
    cfg.loop_close = 1'b0;
    wait_mode(4'h1);
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    cfg = '0;
    cfg.p_exp = 5'h05;
    cfg.man_holdover = 1'b1;
    tick(5);
    chk("no closure word", stw, tw);
    chk("valid after reset", 48'h0, hvalid);
    chk("mode after reset", 48'h1, mode);
    conclude();
  end
endmodule
